/* logic/pps_cfg.svh */
// Constants for the printer port pin block.
// Assumes inclusion by the package and by design modules by bare name.
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH

// -----------------------------------------------------------------
// Widths, reset values, bit levels and synchroniser bit indices
// -----------------------------------------------------------------
`define PPS_DATA_W       8
`define PPS_DATA_RST     8'h00
`define PPS_LINE_IDLE    1'h1
`define PPS_BIT_CLR      1'h0
`define PPS_BIT_SET      1'h1
`define PPS_SYNC_RST     2'h3
`define PPS_SYNC_MSB     1
`define PPS_SYNC_LSB     0

`endif

/* logic/pps_pkg.sv */
// Types shared by the printer port pin block.
// Assumes pps_cfg.svh is on the include path.
`include "pps_cfg.svh"

package pps_pkg;
   // -----------------------------------------------------------------
   // Port operating modes
   // -----------------------------------------------------------------
   typedef enum logic {
      PPS_MODE_STD_COMPAT,
      PPS_MODE_OTHER
   } pps_mode_t;

   // Strobe sequencer states
   typedef enum logic [1:0] {
      PPS_ST_IDLE,
      PPS_ST_SETUP,
      PPS_ST_PULSE,
      PPS_ST_HOLD
   } pps_state_t;

   typedef logic [`PPS_DATA_W-1:0] pps_byte_t;
endpackage

/* logic/pps_port.sv */
// Printer port pin signalling: controls out, status in, irq follow.
// Assumes user side logic on core_clk; pins asynchronous, open drain
// resolved outside (oe high means pulled low / driven).
//
// Contract
// - Compat mode with irq enabled: irq follows done
// - Strobe open-drain low; peripheral latches on rise
// - Auto feed open-drain, low requests continuous feed
// - Choose control open-drain, low selects peripheral
// - Host irq open-drain, low while condition present
`timescale 1ns/1ps
`include "pps_cfg.svh"

module pps_port (
   input  wire logic                   core_clk,
   input  wire logic                   nrst,
   // User side
   input  wire logic                   modeOther,
   input  wire logic                   irqEnable,
   input  wire logic                   dirReceive,
   input  wire logic                   sendReq,
   input  wire logic [`PPS_DATA_W-1:0] sendByte,
   input  wire logic                   autoFeedReq,
   input  wire logic                   periphResetReq,
   input  wire logic                   periphChooseReq,
   output logic                        sendBusy,
   output logic                        statSelected,
   output logic                        statPaperEmpty,
   output logic                        statNotReady,
   output logic                        statFault,
   output logic                        statDoneEvt,
   output logic [`PPS_DATA_W-1:0]      rxByte,
   // Pins
   input  wire logic                   peripheral_selected,
   input  wire logic                   paper_out,
   input  wire logic                   peripheral_not_ready,
   input  wire logic                   transfer_done_n,
   input  wire logic                   error_report_n,
   input  wire logic [`PPS_DATA_W-1:0] print_data_bus_in,
   output logic [`PPS_DATA_W-1:0]      print_data_bus_out,
   output logic [`PPS_DATA_W-1:0]      print_data_bus_oe,
   output logic                        data_latch_pulse_n_out,
   output logic                        data_latch_pulse_n_oe,
   output logic                        auto_line_feed_n_out,
   output logic                        auto_line_feed_n_oe,
   output logic                        peripheral_reset_n_out,
   output logic                        peripheral_reset_n_oe,
   output logic                        peripheral_choose_n_out,
   output logic                        peripheral_choose_n_oe,
   output logic                        host_irq_n_out,
   output logic                        host_irq_n_oe
);
   pps_stat_if stat ();

   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   pps_sync uSync (
      .core_clk             (core_clk),
      .nrst                 (nrst),
      .peripheral_selected  (peripheral_selected),
      .paper_out            (paper_out),
      .peripheral_not_ready (peripheral_not_ready),
      .transfer_done_n      (transfer_done_n),
      .error_report_n       (error_report_n),
      .print_data_bus_in    (print_data_bus_in),
      .stat                 (stat.src)
   );

   // -----------------------------------------------------------------
   // Strobe sequencer state
   // -----------------------------------------------------------------
   pps_pkg::pps_state_t state_ff;
   pps_pkg::pps_state_t nxt_state;
   pps_pkg::pps_byte_t  dataOut_ff;
   pps_pkg::pps_byte_t  nxt_dataOut;
   pps_pkg::pps_mode_t  mode;
   logic                strobeOe_ff;
   logic                nxt_strobeOe;
   logic                busy_ff;
   logic                nxt_busy;

   assign mode = modeOther ? pps_pkg::PPS_MODE_OTHER : pps_pkg::PPS_MODE_STD_COMPAT;

   // Setup, pulse and hold each one cycle; byte stays on the bus
   // past the rising edge so the peripheral latches stable data
   always_comb begin
      nxt_state    = state_ff;
      nxt_dataOut  = dataOut_ff;
      nxt_strobeOe = `PPS_BIT_CLR;
      nxt_busy     = busy_ff;
      case (state_ff)
         pps_pkg::PPS_ST_IDLE: begin
            // Held off while peripheral reports not ready
            if (sendReq && !dirReceive && !stat.notReady) begin
               nxt_dataOut = sendByte;
               nxt_busy    = `PPS_BIT_SET;
               nxt_state   = pps_pkg::PPS_ST_SETUP;
            end else begin
               nxt_busy = `PPS_BIT_CLR;
            end
         end
         pps_pkg::PPS_ST_SETUP: begin
            nxt_strobeOe = `PPS_BIT_SET;
            nxt_state    = pps_pkg::PPS_ST_PULSE;
         end
         pps_pkg::PPS_ST_PULSE: begin
            nxt_state = pps_pkg::PPS_ST_HOLD;
         end
         pps_pkg::PPS_ST_HOLD: begin
            nxt_busy  = `PPS_BIT_CLR;
            nxt_state = pps_pkg::PPS_ST_IDLE;
         end
         default: begin
            nxt_state = pps_pkg::PPS_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_ff    <= pps_pkg::PPS_ST_IDLE;
         dataOut_ff  <= `PPS_DATA_RST;
         strobeOe_ff <= `PPS_BIT_CLR;
         busy_ff     <= `PPS_BIT_CLR;
      end else begin
         state_ff    <= nxt_state;
         dataOut_ff  <= nxt_dataOut;
         strobeOe_ff <= nxt_strobeOe;
         busy_ff     <= nxt_busy;
      end
   end

   // -----------------------------------------------------------------
   // Control, status and irq registers
   // -----------------------------------------------------------------
   logic                       dataOe_ff, nxt_dataOe;
   logic                       feedOe_ff, nxt_feedOe;
   logic                       initOe_ff, nxt_initOe;
   logic                       chooseOe_ff, nxt_chooseOe;
   logic                       irqOe_ff, nxt_irqOe;
   logic                       sel_ff, nxt_sel;
   logic                       paper_ff, nxt_paper;
   logic                       notRdy_ff, nxt_notRdy;
   logic                       fault_ff, nxt_fault;
   logic                       doneDly_ff, nxt_doneDly;
   logic                       doneEvt_ff, nxt_doneEvt;
   logic [`PPS_DATA_W-1:0]     rx_ff, nxt_rx;

   // Open-drain controls: enable high pulls the line low
   always_comb begin
      nxt_dataOe   = !dirReceive;
      nxt_feedOe   = autoFeedReq;
      nxt_initOe   = periphResetReq;
      nxt_chooseOe = periphChooseReq;
      // Irq follows the synchronised done level, one cycle late
      nxt_irqOe    = (mode == pps_pkg::PPS_MODE_STD_COMPAT) && irqEnable
                     && !stat.doneN;
      nxt_sel      = stat.selected;
      nxt_paper    = stat.paperOut;
      nxt_notRdy   = stat.notReady;
      nxt_fault    = !stat.errorN;
      nxt_doneDly  = stat.doneN;
      nxt_doneEvt  = doneDly_ff && !stat.doneN;
      nxt_rx       = dirReceive ? stat.dataIn : rx_ff;
   end

   // Idle everything released, so the peripheral sees no glitch
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         dataOe_ff   <= `PPS_BIT_CLR;
         feedOe_ff   <= `PPS_BIT_CLR;
         initOe_ff   <= `PPS_BIT_CLR;
         chooseOe_ff <= `PPS_BIT_CLR;
         irqOe_ff    <= `PPS_BIT_CLR;
         sel_ff      <= `PPS_BIT_CLR;
         paper_ff    <= `PPS_BIT_CLR;
         notRdy_ff   <= `PPS_BIT_CLR;
         fault_ff    <= `PPS_BIT_CLR;
         doneDly_ff  <= `PPS_LINE_IDLE;
         doneEvt_ff  <= `PPS_BIT_CLR;
         rx_ff       <= `PPS_DATA_RST;
      end else begin
         dataOe_ff   <= nxt_dataOe;
         feedOe_ff   <= nxt_feedOe;
         initOe_ff   <= nxt_initOe;
         chooseOe_ff <= nxt_chooseOe;
         irqOe_ff    <= nxt_irqOe;
         sel_ff      <= nxt_sel;
         paper_ff    <= nxt_paper;
         notRdy_ff   <= nxt_notRdy;
         fault_ff    <= nxt_fault;
         doneDly_ff  <= nxt_doneDly;
         doneEvt_ff  <= nxt_doneEvt;
         rx_ff       <= nxt_rx;
      end
   end

   // -----------------------------------------------------------------
   // Outputs, all from flip-flops; open-drain outs are constant low
   // -----------------------------------------------------------------
   assign sendBusy                = busy_ff;
   assign statSelected            = sel_ff;
   assign statPaperEmpty          = paper_ff;
   assign statNotReady            = notRdy_ff;
   assign statFault               = fault_ff;
   assign statDoneEvt             = doneEvt_ff;
   assign rxByte                  = rx_ff;
   assign print_data_bus_out      = dataOut_ff;
   assign print_data_bus_oe       = {`PPS_DATA_W{dataOe_ff}};
   assign data_latch_pulse_n_out  = `PPS_BIT_CLR;
   assign data_latch_pulse_n_oe   = strobeOe_ff;
   assign auto_line_feed_n_out    = `PPS_BIT_CLR;
   assign auto_line_feed_n_oe     = feedOe_ff;
   assign peripheral_reset_n_out  = `PPS_BIT_CLR;
   assign peripheral_reset_n_oe   = initOe_ff;
   assign peripheral_choose_n_out = `PPS_BIT_CLR;
   assign peripheral_choose_n_oe  = chooseOe_ff;
   assign host_irq_n_out          = `PPS_BIT_CLR;
   assign host_irq_n_oe           = irqOe_ff;
endmodule // pps_port

/* logic/pps_stat_if.sv */
// Synchronised status lines passed from the synchroniser to the top.
// Assumes a single clock domain on both sides.
`timescale 1ns/1ps
`include "pps_cfg.svh"

interface pps_stat_if;
   logic            selected;
   logic            paperOut;
   logic            notReady;
   logic            doneN;
   logic            errorN;
   pps_pkg::pps_byte_t dataIn;

   modport src (output selected, paperOut, notReady, doneN, errorN, dataIn);
   modport dst (input selected, paperOut, notReady, doneN, errorN, dataIn);
endinterface

/* logic/pps_sync.sv */
// Two-flop synchronisers for all printer port inputs.
// Assumes pins are asynchronous to core_clk.
`timescale 1ns/1ps
`include "pps_cfg.svh"

module pps_sync (
   input  wire logic                   core_clk,
   input  wire logic                   nrst,
   input  wire logic                   peripheral_selected,
   input  wire logic                   paper_out,
   input  wire logic                   peripheral_not_ready,
   input  wire logic                   transfer_done_n,
   input  wire logic                   error_report_n,
   input  wire logic [`PPS_DATA_W-1:0] print_data_bus_in,
   pps_stat_if.src                     stat
);
   localparam int NLINE = `PPS_DATA_W + 5;

   logic [NLINE-1:0] rawIn;
   logic [NLINE-1:0] syncOut;

   assign rawIn = {print_data_bus_in, error_report_n, transfer_done_n,
                   peripheral_not_ready, paper_out, peripheral_selected};

   // -----------------------------------------------------------------
   // One synchroniser per line; first stage feeds only the second
   // -----------------------------------------------------------------
   for (genvar i = 0; i < NLINE; i++) begin : gSync
      logic [1:0] sync_ff;
      logic [1:0] nxt_sync;
      // Shift toward the second stage
      always_comb begin
         nxt_sync = {sync_ff[`PPS_SYNC_LSB], rawIn[i]};
      end
      // Idle high matches the pull-ups on the pins
      always_ff @(posedge core_clk or negedge nrst) begin
         if (!nrst) begin
            sync_ff <= `PPS_SYNC_RST;
         end else begin
            sync_ff <= nxt_sync;
         end
      end
      assign syncOut[i] = sync_ff[`PPS_SYNC_MSB];
   end

   assign stat.selected = syncOut[0];
   assign stat.paperOut = syncOut[1];
   assign stat.notReady = syncOut[2];
   assign stat.doneN    = syncOut[3];
   assign stat.errorN   = syncOut[4];
   assign stat.dataIn   = syncOut[NLINE-1:5];
endmodule // pps_sync

/* test/pps_port_properties.sv */
// Checker for the printer port pin block.
// Assumes it is bound to pps_port and sees only its ports.
`timescale 1ns/1ps
`include "pps_cfg.svh"
module pps_port_properties (
   input wire logic                   core_clk,
   input wire logic                   nrst,
   input wire logic                   modeOther,
   input wire logic                   irqEnable,
   input wire logic                   dirReceive,
   input wire logic                   sendReq,
   input wire logic                   sendBusy,
   input wire logic                   transfer_done_n,
   input wire logic                   autoFeedReq,
   input wire logic                   periphResetReq,
   input wire logic                   periphChooseReq,
   input wire logic [`PPS_DATA_W-1:0] print_data_bus_oe,
   input wire logic                   data_latch_pulse_n_oe,
   input wire logic                   auto_line_feed_n_oe,
   input wire logic                   peripheral_reset_n_oe,
   input wire logic                   peripheral_choose_n_oe,
   input wire logic                   host_irq_n_out,
   input wire logic                   host_irq_n_oe
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // ----------------------------------------------
   // Sequences
   // ----------------------------------------------
   // Held four edges, so the 3-edge pin path has settled
   sequence s_irq_armed;
      (!modeOther && irqEnable) [*4];
   endsequence
   sequence s_strobe;
      !data_latch_pulse_n_oe ##1 data_latch_pulse_n_oe ##1
      (!data_latch_pulse_n_oe && sendBusy) ##1 !sendBusy;
   endsequence
   // ----------------------------------------------
   // Properties
   // ----------------------------------------------
   AST_IRQ_FOLLOW: assert property (
      s_irq_armed |-> host_irq_n_oe == !$past(transfer_done_n, 3))
      else $error("irq does not follow done");
   AST_IRQ_MODE: assert property (
      modeOther [*4] |-> !host_irq_n_oe)
      else $error("irq driven outside compat mode");
   AST_IRQ_OFF: assert property (
      !$past(irqEnable) |-> !host_irq_n_oe)
      else $error("irq driven while disabled");
   AST_IRQ_OD: assert property (
      host_irq_n_oe |-> !host_irq_n_out && !$past(transfer_done_n, 3))
      else $error("irq low without cause");
   AST_STROBE_SEQ: assert property (
      $rose(sendBusy) |-> s_strobe)
      else $error("strobe sequence wrong");
   AST_SEND_CAUSE: assert property (
      $rose(sendBusy) |-> $past(sendReq) && !$past(dirReceive))
      else $error("send started without request");
   AST_FEED: assert property (
      auto_line_feed_n_oe == $past(autoFeedReq))
      else $error("feed line wrong");
   AST_INIT: assert property (
      peripheral_reset_n_oe == $past(periphResetReq))
      else $error("init line wrong");
   AST_CHOOSE: assert property (
      peripheral_choose_n_oe == $past(periphChooseReq))
      else $error("choose line wrong");
   AST_DATA_DIR: assert property (
      $past(nrst) |-> print_data_bus_oe == {`PPS_DATA_W{!$past(dirReceive)}})
      else $error("data direction wrong");
endmodule // pps_port_properties

bind pps_port pps_port_properties u_pps_port_properties (
   .core_clk, .nrst, .modeOther, .irqEnable, .dirReceive, .sendReq, .sendBusy,
   .transfer_done_n, .autoFeedReq, .periphResetReq, .periphChooseReq,
   .print_data_bus_oe, .data_latch_pulse_n_oe, .auto_line_feed_n_oe,
   .peripheral_reset_n_oe, .peripheral_choose_n_oe, .host_irq_n_out, .host_irq_n_oe
);

/* test/pps_printer_model.sv */
// Behavioural printer on the far side of the port.
// Assumes open-drain lines already resolved with pull-ups.
`timescale 1ns/1ps
`include "pps_cfg.svh"
module pps_printer_model (
   input  wire logic                   strobeLine,
   input  wire logic                   initLine,
   input  wire logic [`PPS_DATA_W-1:0] dataLine,
   input  wire logic                   slow,
   input  wire logic                   jam,
   input  wire logic                   online,
   input  wire logic                   noPaper,
   input  wire logic                   broken,
   output logic                        peripheral_selected,
   output logic                        paper_out,
   output logic                        peripheral_not_ready,
   output logic                        transfer_done_n,
   output logic                        error_report_n,
   output logic [`PPS_DATA_W-1:0]      lastByte,
   output int                          gotCnt,
   output int                          initCnt
);
   logic busyFf = 1'h0;
   // Status pins follow the commanded condition; not ready is also raised while busy
   assign peripheral_selected = online;
   assign paper_out = noPaper;
   assign error_report_n = !broken;
   assign peripheral_not_ready = busyFf | jam;
   initial transfer_done_n = 1'h1;
   initial gotCnt = 0;
   initial initCnt = 0;
   // Latch on rise; busy until acknowledge ends, so no overrun
   // Delays sit off the clock edge, so pin changes never race it
   always @(posedge strobeLine) begin
      lastByte = dataLine;
      gotCnt++;
      busyFf = 1'h1;
      #(slow ? 810 : 210);
      transfer_done_n = 1'h0;
      #(slow ? 410 : 160);
      transfer_done_n = 1'h1;
      busyFf = 1'h0;
   end
   // Each falling edge starts an initialisation
   always @(negedge initLine) initCnt++;
endmodule // pps_printer_model

/* test/tb.sv */
// Self-checking bench for the printer port pin block.
// Assumes the design files and the printer model are compiled first.
`timescale 1ns/1ps
module tb;
   logic core_clk = 1'h0, nrst = 1'h0, modeOther = 1'h0, irqEnable = 1'h1;
   logic dirReceive = 1'h0, sendReq = 1'h0, autoFeedReq = 1'h0;
   logic periphResetReq = 1'h0, periphChooseReq = 1'h0, slow = 1'h0, jam = 1'h0;
   logic online = 1'h1, noPaper = 1'h0, broken = 1'h0, irqSeen, doneEvt;
   pps_pkg::pps_byte_t sendByte = 8'h00, rxVal = 8'h00, rxByte, lastByte;
   pps_pkg::pps_byte_t print_data_bus_in, print_data_bus_out, print_data_bus_oe;
   logic sendBusy, statSelected, statPaperEmpty, statNotReady, statFault, statDoneEvt;
   logic peripheral_selected, paper_out, peripheral_not_ready, transfer_done_n;
   logic error_report_n, data_latch_pulse_n_out, data_latch_pulse_n_oe;
   logic auto_line_feed_n_out, auto_line_feed_n_oe, peripheral_reset_n_out;
   logic peripheral_reset_n_oe, peripheral_choose_n_out, peripheral_choose_n_oe;
   logic host_irq_n_out, host_irq_n_oe;
   int n_errors = 0, cmp_count = 0, cyc = 0, gotCnt, initCnt;
   // Open-drain lines resolved with pull-ups
   wire strobeLine = (data_latch_pulse_n_oe === 1'h1) ? data_latch_pulse_n_out : 1'h1;
   wire afLine = (auto_line_feed_n_oe === 1'h1) ? auto_line_feed_n_out : 1'h1;
   wire initLine = (peripheral_reset_n_oe === 1'h1) ? peripheral_reset_n_out : 1'h1;
   wire pcLine = (peripheral_choose_n_oe === 1'h1) ? peripheral_choose_n_out : 1'h1;
   wire irqLine = (host_irq_n_oe === 1'h1) ? host_irq_n_out : 1'h1;
   wire [7:0] dataLine = print_data_bus_in;
   assign print_data_bus_in = (print_data_bus_oe === 8'hFF) ? print_data_bus_out : rxVal;
   pps_port u_pps_port (.core_clk, .nrst, .modeOther, .irqEnable, .dirReceive, .sendReq,
      .sendByte, .autoFeedReq, .periphResetReq, .periphChooseReq, .sendBusy, .statSelected,
      .statPaperEmpty, .statNotReady, .statFault, .statDoneEvt, .rxByte, .peripheral_selected,
      .paper_out, .peripheral_not_ready, .transfer_done_n, .error_report_n, .print_data_bus_in,
      .print_data_bus_out, .print_data_bus_oe, .data_latch_pulse_n_out, .data_latch_pulse_n_oe,
      .auto_line_feed_n_out, .auto_line_feed_n_oe, .peripheral_reset_n_out,
      .peripheral_reset_n_oe, .peripheral_choose_n_out, .peripheral_choose_n_oe,
      .host_irq_n_out, .host_irq_n_oe);
   pps_printer_model u_pps_printer_model (.strobeLine, .initLine, .dataLine, .slow, .jam,
      .online, .noPaper, .broken, .peripheral_selected, .paper_out, .peripheral_not_ready,
      .transfer_done_n, .error_report_n, .lastByte, .gotCnt, .initCnt);
   // Clock, event catchers and hang guard
   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (irqLine === 1'h0) irqSeen <= 1'h1;
      if (statDoneEvt === 1'h1) doneEvt <= 1'h1;
      if (cyc == 4000) begin
         n_errors++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'h1) begin
         n_errors++;
         $display("ERROR at %0t: %s", $time, msg);
      end
   endtask
   // Inputs always change 2 ns after the rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask
   task automatic t_status();
      for (int k = 0; k < 8; k++) begin
         {broken, noPaper, online} = k[2:0];
         tick(4);
         chk({statFault, statPaperEmpty, statSelected} === k[2:0], "status");
      end
      {broken, noPaper, online} = 3'h1;
      $display("test status done");
   endtask
   task automatic t_ctrl();
      for (int k = 0; k < 3; k++) begin
         {autoFeedReq, periphResetReq, periphChooseReq} = 3'h4 >> k;
         tick(2);
         chk({afLine, initLine, pcLine} === ~(3'h4 >> k), "control");
      end
      {autoFeedReq, periphResetReq, periphChooseReq} = 3'h0;
      tick(2);
      chk(initCnt === 1 && {afLine, initLine, pcLine} === 3'h7, "init");
      $display("test controls done");
   endtask
   task automatic t_send(input pps_pkg::pps_byte_t b, input logic sl, input logic md,
                         input logic ie);
      int n0 = gotCnt;
      {slow, modeOther, irqEnable, sendByte, sendReq} = {sl, md, ie, b, 1'h1};
      irqSeen = 1'h0;
      doneEvt = 1'h0;
      tick(1);
      sendReq = 1'h0;
      for (int i = 0; i < 20 && gotCnt == n0; i++) tick(1);
      chk(gotCnt == n0 + 1 && lastByte === b, "byte");
      for (int i = 0; i < 90 && peripheral_not_ready !== 1'h0; i++) tick(1);
      tick(4);
      chk(irqSeen === (!md && ie) && irqLine === 1'h1, "irq");
      chk(doneEvt === 1'h1, "done event");
      $display("test send done");
   endtask
   task automatic t_refuse();
      int n0 = gotCnt;
      jam = 1'h1;
      tick(4);
      sendReq = 1'h1;
      tick(3);
      chk(statNotReady === 1'h1 && sendBusy === 1'h0, "not ready");
      {sendReq, jam, dirReceive, rxVal} = {3'h1, 8'h5A};
      tick(4);
      chk(print_data_bus_oe === 8'h00 && rxByte === 8'h5A, "receive");
      sendReq = 1'h1;
      tick(3);
      chk(sendBusy === 1'h0 && gotCnt == n0, "send in receive");
      {sendReq, dirReceive} = 2'h0;
      tick(2);
      chk(print_data_bus_oe === 8'hFF, "drive");
      $display("test refuse done");
   endtask
   initial begin
      tick(20);
      nrst = 1'h1;
      tick(2);
      t_status();
      t_ctrl();
      t_send(8'hA5, 1'h0, 1'h0, 1'h1);
      t_send(8'h3C, 1'h1, 1'h0, 1'h1);
      t_send(8'hFF, 1'h0, 1'h1, 1'h1);
      t_send(8'h0F, 1'h0, 1'h0, 1'h0);
      t_refuse();
      stop_test();
   end
endmodule // tb
